// File: logic/xrts_defines.svh
// Purpose: Constants of the transceiver reset and test status block
// Assumes: Byte addresses on a 32-bit Wishbone bus
// Notes: Definitions only
`ifndef XRTS_DEFINES_SVH
`define XRTS_DEFINES_SVH
`define XRTS_ADR_CTRL 8'h00
`define XRTS_ADR_STAT 8'h04
`define XRTS_ADR_IRQ 8'h08
`define XRTS_ADR_MASK 8'h0c
`define XRTS_ADR_PLEN 8'h10
`define XRTS_CTRL_TEST 0
`define XRTS_CTRL_MODE_LO 1
`define XRTS_CTRL_MODE_HI 2
`define XRTS_CTRL_RST 3'h0
`define XRTS_PLEN_RST 16'h007f
`define XRTS_EV_DONE 0
`define XRTS_EV_ERR 1
`define XRTS_EV_OFS 2
`define XRTS_CLK_HZ 40000000
`define XRTS_OFS_TIME_NS 2000
`define XRTS_ERR_MIN_CYC 3
`endif

// File: logic/xrts_pkg.sv
// Purpose: Types of the transceiver reset and test status block
// Assumes: Included before the top module
// Notes: Constants live in xrts_defines.svh
package xrts_pkg;
	typedef enum logic [1:0] {
		XRTS_BIST = 2'h0,
		XRTS_PRBS = 2'h1,
		XRTS_NORM = 2'h2,
		XRTS_PIPE = 2'h3
	} xrts_mode_e;
	typedef enum logic [1:0] {
		XRTS_OFS_IDLE = 2'b00,
		XRTS_OFS_RUN = 2'b01,
		XRTS_OFS_DONE = 2'b11
	} xrts_ofs_e;
	typedef struct packed {
		logic tx_pcs;
		logic rx_pma;
		logic rx_pcs;
	} xrts_rst_s;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} xrts_wb_req_s;
endpackage : xrts_pkg

// File: logic/xrts_top.sv
// Purpose: Reset, power-down and self-test status logic of a serial transceiver
// Assumes: One 40 MHz clock serves as parallel, recovered and reconfiguration clock
// Notes: Registers over classic Wishbone; verifier words arrive on vrf_valid
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`include "xrts_defines.svh"
module xrts_top #(
	parameter int PLEN_W = 16,
	parameter int OFS_CYC = (`XRTS_OFS_TIME_NS * (`XRTS_CLK_HZ / 1000000)) / 1000
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Wishbone slave
	input xrts_pkg::xrts_wb_req_s wb_req,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Asynchronous control pins
	input wire logic gxb_pwrdn,
	input wire logic tx_pcs_rst_in,
	input wire logic rx_pma_rst_in,
	input wire logic rx_pcs_rst_in,
	// Verifier word stream
	input wire logic vrf_valid,
	input wire logic vrf_mismatch,
	// Resets and power
	output xrts_pkg::xrts_rst_s rst_out,
	output logic core_pwr_en,
	output logic refclk_buf_en,
	output logic ofs_cal_run,
	// Status
	output logic test_done,
	output logic vrf_err,
	output logic irq
);
	import xrts_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers
	logic [1:0] rsync_reg;
	logic rst_s_n;
	logic [1:0] pd_sync_reg;
	logic pd;
	logic [2:0] rst_pin;
	xrts_rst_s rst_chain;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsync_reg <= 2'h0;
		end else begin
			rsync_reg <= {rsync_reg[0], 1'b1};
		end
	end
	assign rst_s_n = rsync_reg[1];
	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			pd_sync_reg <= 2'h3;
		end else begin
			pd_sync_reg <= {pd_sync_reg[0], gxb_pwrdn};
		end
	end
	assign pd = pd_sync_reg[1];
	// Pins assert at once; release waits two edges
	assign rst_pin = {tx_pcs_rst_in, rx_pma_rst_in, rx_pcs_rst_in};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_rsync
			logic [1:0] ch_reg;
			always_ff @(posedge sys_clk or posedge rst_pin[gi] or negedge rst_s_n) begin
				if (rst_pin[gi] || !rst_s_n) begin
					ch_reg <= 2'h3;
				end else begin
					ch_reg <= {ch_reg[0], 1'b0};
				end
			end
			assign rst_chain[gi] = ch_reg[1];
		end
	endgenerate
	// Power-down forces every coding and analog reset as well
	assign rst_out = rst_chain | {3{pd}};
	assign core_pwr_en = !pd;
	// Reference buffers stay on so the link can relock fast
	assign refclk_buf_en = rst_s_n;

	////////////////////////////////////////////////////////////////////////////////
	// Registers and Wishbone decode
	logic [2:0] ctrl_reg;
	logic [2:0] irq_reg;
	logic [2:0] mask_reg;
	logic [PLEN_W-1:0] plen_reg;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [31:0] rdat_next;
	logic acc;
	logic wr;
	xrts_mode_e mode;
	logic [2:0] ev;
	logic [2:0] stat;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction : hit
	assign acc = wb_req.cyc && wb_req.stb && !ack_reg;
	assign wr = acc && wb_req.we && wb_req.sel[0];
	assign mode = xrts_mode_e'(ctrl_reg[`XRTS_CTRL_MODE_HI:`XRTS_CTRL_MODE_LO]);
	assign stat = {pd, vrf_err, test_done};
	assign rdat_next = hit(wb_req.adr, `XRTS_ADR_CTRL) ? {29'h0, ctrl_reg} :
		hit(wb_req.adr, `XRTS_ADR_STAT) ? {24'h0, ofs_cal_run, rst_out, 1'h0, stat} :
		hit(wb_req.adr, `XRTS_ADR_IRQ) ? {29'h0, irq_reg} :
		hit(wb_req.adr, `XRTS_ADR_MASK) ? {29'h0, mask_reg} :
		hit(wb_req.adr, `XRTS_ADR_PLEN) ? {{(32-PLEN_W){1'b0}}, plen_reg} : 32'h0;

	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0;
		end else begin
			ack_reg <= acc;
			rdat_reg <= rdat_next;
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
	// Plen is written only with both sel[0] and sel[1]
	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			ctrl_reg <= `XRTS_CTRL_RST;
			mask_reg <= 3'h0;
			plen_reg <= PLEN_W'(`XRTS_PLEN_RST);
		end else begin
			if (wr && hit(wb_req.adr, `XRTS_ADR_CTRL))
				ctrl_reg <= wb_req.dat[2:0];
			if (wr && hit(wb_req.adr, `XRTS_ADR_MASK))
				mask_reg <= wb_req.dat[2:0];
			if (wr && wb_req.sel[1] && hit(wb_req.adr, `XRTS_ADR_PLEN))
				plen_reg <= wb_req.dat[PLEN_W-1:0];
		end
	end

	// Sticky events; a new event beats a same-cycle clear
	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			irq_reg <= 3'h0;
		end else if (wr && hit(wb_req.adr, `XRTS_ADR_IRQ)) begin
			irq_reg <= (irq_reg & ~wb_req.dat[2:0]) | ev;
		end else begin
			irq_reg <= irq_reg | ev;
		end
	end
	assign irq = |(irq_reg & mask_reg);
	////////////////////////////////////////////////////////////////////////////////
	// Pattern verifier status
	logic [PLEN_W-1:0] wcnt_reg;
	logic seq_err_reg;
	logic done_reg;
	logic err_reg;
	logic [1:0] hold_reg;
	logic go;
	logic wrap;
	logic bist;
	logic prbs;
	logic clean_end;

	assign go = ctrl_reg[`XRTS_CTRL_TEST] && !rst_out.rx_pcs && vrf_valid;
	assign wrap = go && (wcnt_reg == plen_reg);
	assign bist = mode == XRTS_BIST;
	assign prbs = mode == XRTS_PRBS;
	assign clean_end = wrap && !seq_err_reg && !vrf_mismatch;

	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			wcnt_reg <= '0;
			seq_err_reg <= 1'b0;
		end else if (rst_out.rx_pcs) begin
			wcnt_reg <= '0;
			seq_err_reg <= 1'b0;
		end else if (go) begin
			wcnt_reg <= wrap ? '0 : wcnt_reg + 1'b1;
			seq_err_reg <= !wrap && (seq_err_reg || vrf_mismatch);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			done_reg <= 1'b0;
		end else if (rst_out.rx_pcs) begin
			done_reg <= 1'b0;
		end else if (bist && (wrap || (go && vrf_mismatch))) begin
			done_reg <= 1'b1;
		end else if (prbs && wrap) begin
			done_reg <= 1'b1;
		end
	end

	// BIST and PRBS error; in PRBS a minimum hold, then cleared by a clean sequence
	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			err_reg <= 1'b0;
			hold_reg <= 2'h0;
		end else if (rst_out.rx_pcs) begin
			err_reg <= 1'b0;
			hold_reg <= 2'h0;
		end else if (go && vrf_mismatch && (bist || prbs)) begin
			err_reg <= 1'b1;
			hold_reg <= 2'(`XRTS_ERR_MIN_CYC - 1);
		end else if (hold_reg != 2'h0) begin
			hold_reg <= hold_reg - 2'h1;
		end else if (prbs && clean_end) begin
			err_reg <= 1'b0;
		end
	end
	assign test_done = done_reg;
	assign vrf_err = err_reg;
	////////////////////////////////////////////////////////////////////////////////
	// Receiver offset cancellation
	xrts_ofs_e ofs_reg;
	xrts_ofs_e ofs_next;
	logic [15:0] ocnt_reg;
	logic ofs_end;

	assign ofs_end = ocnt_reg == 16'(OFS_CYC - 1);
	always_comb begin
		ofs_next = ofs_reg;
		case (ofs_reg)
			XRTS_OFS_IDLE: begin
				if (!rst_out.rx_pma && mode != XRTS_PIPE)
					ofs_next = XRTS_OFS_RUN;
			end
			XRTS_OFS_RUN: begin
				if (ofs_end)
					ofs_next = XRTS_OFS_DONE;
			end
			XRTS_OFS_DONE: ofs_next = XRTS_OFS_DONE;
			default: ofs_next = XRTS_OFS_IDLE;
		endcase
		// PIPE mode or analog reset aborts and rearms
		if (rst_out.rx_pma || mode == XRTS_PIPE)
			ofs_next = XRTS_OFS_IDLE;
	end

	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			ofs_reg <= XRTS_OFS_IDLE;
			ocnt_reg <= 16'h0;
		end else begin
			ofs_reg <= ofs_next;
			ocnt_reg <= (ofs_reg == XRTS_OFS_RUN) ? ocnt_reg + 16'h1 : 16'h0;
		end
	end
	assign ofs_cal_run = ofs_reg == XRTS_OFS_RUN;
	logic done_d_reg;
	logic err_d_reg;
	always_ff @(posedge sys_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			done_d_reg <= 1'b0;
			err_d_reg <= 1'b0;
		end else begin
			done_d_reg <= done_reg;
			err_d_reg <= err_reg;
		end
	end
	assign ev[`XRTS_EV_DONE] = done_reg && !done_d_reg;
	assign ev[`XRTS_EV_ERR] = err_reg && !err_d_reg;
	assign ev[`XRTS_EV_OFS] = ofs_cal_run && ofs_end;
	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_s_n);
	property p_pd_off;
		pd |-> !core_pwr_en && (rst_out == 3'h7);
	endproperty
	a_pd_off: assert property (p_pd_off) else $error("power-down left logic on");
	property p_refclk;
		pd |-> refclk_buf_en;
	endproperty
	a_refclk: assert property (p_refclk) else $error("refclk buffer off");
	property p_tx_rst;
		tx_pcs_rst_in |-> rst_out.tx_pcs;
	endproperty
	a_tx_rst: assert property (p_tx_rst) else $error("tx reset not held");
	// Calibration state only sees the reset at the next edge
	property p_pma_rst;
		rx_pma_rst_in |-> rst_out.rx_pma ##1 !ofs_cal_run;
	endproperty
	a_pma_rst: assert property (p_pma_rst) else $error("rx analog reset not held");
	property p_rxd_clr;
		rst_out.rx_pcs |=> !test_done && !vrf_err;
	endproperty
	a_rxd_clr: assert property (p_rxd_clr) else $error("flags not cleared");
	property p_pipe_ofs;
		mode == XRTS_PIPE |=> !ofs_cal_run;
	endproperty
	a_pipe_ofs: assert property (p_pipe_ofs) else $error("offset cal in pipe");
	property p_bist_done;
		bist && go && vrf_mismatch |=> test_done;
	endproperty
	a_bist_done: assert property (p_bist_done) else $error("bist done missing");
	property p_done_hold;
		test_done && !rst_out.rx_pcs |=> test_done;
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("done dropped");
	property p_prbs_done;
		prbs && wrap |=> test_done;
	endproperty
	a_prbs_done: assert property (p_prbs_done) else $error("prbs done missing");
	property p_bist_err;
		bist && vrf_err && !rst_out.rx_pcs |=> vrf_err;
	endproperty
	a_bist_err: assert property (p_bist_err) else $error("bist error dropped");
	property p_prbs_min;
		prbs && !rst_out.rx_pcs && $rose(vrf_err) |-> vrf_err[*3] or ##[1:2] rst_out.rx_pcs;
	endproperty
	a_prbs_min: assert property (p_prbs_min) else $error("prbs error too short");
	property p_rel_sync;
		$fell(tx_pcs_rst_in) && rst_s_n |-> rst_chain.tx_pcs[*2];
	endproperty
	a_rel_sync: assert property (p_rel_sync) else $error("reset released early");
	c_bist_done: cover property (bist && $rose(test_done));
	c_prbs_clear: cover property (prbs && $fell(vrf_err));
	c_ofs_done: cover property (ev[`XRTS_EV_OFS]);
	c_irq: cover property ($rose(irq));
endmodule : xrts_top

// File: bench/xrts_fabric_model.sv
// Purpose: Fabric-side reset pins and verifier word stream
// Assumes: Tasks are entered just after a rising edge
// Notes: Idle mismatch line is driven high; go qualifies it with vrf_valid
`timescale 1ns/10ps
module xrts_fabric_model (
	// Clock
	input wire logic sys_clk,
	// Toward the block
	output xrts_pkg::xrts_rst_s rst_pins,
	output logic vrf_valid,
	output logic vrf_mismatch
);
	import xrts_pkg::*;
	initial begin
		rst_pins = '0;
		vrf_valid = 1'b0;
		vrf_mismatch = 1'b1;
	end
	////////////////////////////////////////
	// Short pulses are stretched to the legal minimum
	task automatic pulse(input logic [2:0] m, input int n);
		rst_pins <= m;
		repeat ((n < 2) ? 2 : n) @(posedge sys_clk);
		rst_pins <= '0;
	endtask : pulse
	task automatic send(input int n, input int bad);
		for (int i = 0; i < n; i++) begin
			vrf_valid <= 1'b1;
			vrf_mismatch <= (i == bad);
			@(posedge sys_clk);
		end
		vrf_valid <= 1'b0;
		vrf_mismatch <= 1'b1;
	endtask : send
endmodule : xrts_fabric_model

// File: bench/xrts_top_tb.sv
// Purpose: Self-checking bench of xrts_top
// Assumes: OFS_CYC shortened to 4, pattern length 4 words
// Notes: Outputs are read just after an edge, before its updates land
`timescale 1ns/10ps
`include "xrts_defines.svh"
module xrts_top_tb;
	import xrts_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic gxb_pwrdn = 1'b0;
	xrts_wb_req_s req = '0;
	xrts_rst_s pins;
	xrts_rst_s rst_out;
	logic [31:0] wb_dat_o;
	logic [31:0] q;
	logic wb_ack_o, vld, mis, core_pwr_en, refclk_buf_en, ofs_cal_run, test_done, vrf_err, irq;
	int n_errors = 0;
	int checked = 0;
	int n;
	always #12.5 sys_clk = ~sys_clk;
	xrts_top #(.OFS_CYC(4)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_req(req),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gxb_pwrdn(gxb_pwrdn),
		.tx_pcs_rst_in(pins.tx_pcs), .rx_pma_rst_in(pins.rx_pma),
		.rx_pcs_rst_in(pins.rx_pcs), .vrf_valid(vld), .vrf_mismatch(mis),
		.rst_out(rst_out), .core_pwr_en(core_pwr_en), .refclk_buf_en(refclk_buf_en),
		.ofs_cal_run(ofs_cal_run), .test_done(test_done), .vrf_err(vrf_err), .irq(irq));
	xrts_fabric_model fm (.sys_clk(sys_clk), .rst_pins(pins), .vrf_valid(vld),
		.vrf_mismatch(mis));
	////////////////////////////////////////
	task automatic stop_test();
		$display("Errors %0d, checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Released request shows inverted fields, not the old ones
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		req <= '{1'b1, 1'b1, w, a, 4'hf, d};
		@(posedge sys_clk);
		while (wb_ack_o !== 1'b1) begin
			i++;
			if (i > 20) begin
				n_errors++;
				stop_test();
			end
			@(posedge sys_clk);
		end
		q = wb_dat_o;
		req <= '{1'b0, 1'b0, ~w, ~a, 4'h0, ~d};
		@(posedge sys_clk);
	endtask : wb
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : tick
	////////////////////////////////////////
	initial begin
		tick(10);
		rst_n <= 1'b1;
		tick(4);
		wb(1'b0, `XRTS_ADR_CTRL, 32'h0);
		chk("ctrl", q, 32'h0);
		wb(1'b0, `XRTS_ADR_PLEN, 32'h0);
		chk("plen", q, 32'h7f);
		chk("refclk", refclk_buf_en, 32'h1);
		chk("rst_out", rst_out, 32'h0);
		gxb_pwrdn <= 1'b1;
		tick(4);
		chk("pwr", core_pwr_en, 32'h0);
		chk("rst_pd", rst_out, 32'h7);
		chk("refclk_pd", refclk_buf_en, 32'h1);
		wb(1'b0, `XRTS_ADR_STAT, 32'h0);
		chk("stat_pd", q, 32'h74);
		gxb_pwrdn <= 1'b0;
		tick(5);
		chk("pwr_up", core_pwr_en, 32'h1);
		for (int k = 0; k < 3; k++) begin
			fork
				fm.pulse(3'h1 << k, 2);
				begin
					tick(1);
					chk("rst_in", rst_out, 32'h1 << k);
				end
			join
			tick(2);
			chk("rst_hold", rst_out, 32'h1 << k);
			tick(1);
			chk("rst_rel", rst_out, 32'h0);
		end
		wb(1'b1, `XRTS_ADR_IRQ, 32'h7);
		fm.pulse(3'h2, 2);
		for (n = 0; ofs_cal_run !== 1'b1 && n < 20; n++)
			tick(1);
		for (n = 0; ofs_cal_run === 1'b1 && n < 20; n++)
			tick(1);
		chk("ofs_len", n, 32'h4);
		wb(1'b0, `XRTS_ADR_IRQ, 32'h0);
		chk("irq_ofs", q[2], 32'h1);
		wb(1'b1, `XRTS_ADR_CTRL, 32'h6);
		fm.pulse(3'h2, 2);
		tick(4);
		chk("ofs_pipe", ofs_cal_run, 32'h0);
		wb(1'b1, `XRTS_ADR_PLEN, 32'h3);
		wb(1'b1, `XRTS_ADR_CTRL, 32'h1);
		fm.pulse(3'h1, 2);
		tick(3);
		fm.send(3, -1);
		tick(1);
		chk("done_early", test_done, 32'h0);
		fm.send(1, -1);
		tick(1);
		chk("done_b", test_done, 32'h1);
		chk("err_b", vrf_err, 32'h0);
		chk("irq_off", irq, 32'h0);
		wb(1'b1, `XRTS_ADR_MASK, 32'h1);
		chk("irq_on", irq, 32'h1);
		wb(1'b1, `XRTS_ADR_IRQ, 32'h1);
		chk("irq_clr", irq, 32'h0);
		fm.pulse(3'h1, 2);
		tick(3);
		chk("done_rst", test_done, 32'h0);
		fm.send(1, 0);
		tick(1);
		chk("done_e", test_done, 32'h1);
		fm.send(8, -1);
		tick(1);
		chk("err_hold", vrf_err, 32'h1);
		fm.pulse(3'h1, 2);
		tick(3);
		chk("err_rst", vrf_err, 32'h0);
		wb(1'b1, `XRTS_ADR_CTRL, 32'h3);
		fm.pulse(3'h1, 2);
		tick(3);
		fm.send(1, 0);
		for (int k = 0; k < 3; k++) begin
			tick(1);
			chk("err_p", vrf_err, 32'h1);
		end
		chk("done_p", test_done, 32'h0);
		fm.send(3, -1);
		tick(1);
		chk("done_p2", test_done, 32'h1);
		chk("err_p2", vrf_err, 32'h1);
		fm.send(4, -1);
		tick(1);
		chk("err_clr", vrf_err, 32'h0);
		wb(1'b0, 8'h20, 32'h0);
		chk("unmapped", q, 32'h0);
		stop_test();
	end
endmodule : xrts_top_tb
